// file: judr_scan_instance.sv
// scan instance: tap tracker, virtual instruction register, state flags
//
// What this block, its user logic and the host do
// RQ1 - scan clock goes out to user logic
// RQ2 - tms output follows the jtag tms pin
// RQ3 - virtual instruction shown as parallel bus
// RQ4 - user logic decodes instruction to pick chain
// RQ5 - user register selected when instruction is 10
// RQ6 - instruction scan rewrites virtual instruction register
// RQ7 - four-bit user register shifts tdi into msb
// RQ8 - shift-dr flag high while tdi valid
// RQ9 - exit1-dr flag high after shifting ends
// RQ10 - counter loads on exit1, else increments
// RQ11 - bypass bit drives return when unselected
// RQ12 - selected register returns its bit zero
// RQ13 - further flags for other tap states
// RQ14 - instance joins user logic and jtag port
// RQ15 - bypass captures tdi every scan clock
// RQ16 - host holds tms high five cycles after reset
`timescale 1ns/1ps
module judr_scan_instance (
    input wire logic tck,
    input wire logic nrst,
    input wire logic tms_pin,
    input wire logic tdi_pin,
    output logic tdo_pin_o,
    output logic tdo_pin_oe,
    judr_link_if.dev_mp link
);

    // ------------------------------------------------------------------
    // pass-through toward user logic
    // ------------------------------------------------------------------
    // the jtag pins already live on tck, so they need no synchroniser
    assign link.scan_clk = tck; // RQ1
    assign link.tms = tms_pin; // RQ2
    assign link.tdi = tdi_pin; // RQ14

    // ------------------------------------------------------------------
    // tms-high run counter
    // ------------------------------------------------------------------
    // a second path into reset that does not rely on the state register,
    // so even an upset one-hot code lands in test-logic-reset once the
    // host has held tms high for the full run; the state graph gets there
    // on its own as well, so this only adds margin
    localparam int RUN_W = $clog2(judr_pkg::TAP_RESET_TMS_CYCLES + 1);
    logic [RUN_W-1:0] tms_run_q;
    logic tms_run_full;

    assign tms_run_full = (tms_run_q == RUN_W'(judr_pkg::TAP_RESET_TMS_CYCLES - 32'h1));

    always_ff @(posedge tck or negedge nrst) begin
        if (!nrst) begin
            tms_run_q <= {RUN_W{1'b0}};
        end else if (!tms_pin) begin
            tms_run_q <= {RUN_W{1'b0}};
        end else if (!tms_run_full) begin
            tms_run_q <= tms_run_q + RUN_W'(32'h1);
        end
    end

    // ------------------------------------------------------------------
    // tap state tracker
    // ------------------------------------------------------------------
    judr_pkg::judr_tap_state_t state_q;
    judr_pkg::judr_tap_state_t state_d;

    // tms held high walks any state into reset within five edges
    always_comb begin
        state_d = judr_pkg::TAP_RESET;
        unique case (state_q)
            judr_pkg::TAP_RESET: begin
                state_d = tms_pin ? judr_pkg::TAP_RESET : judr_pkg::TAP_IDLE;
            end
            judr_pkg::TAP_IDLE: begin
                state_d = tms_pin ? judr_pkg::TAP_SEL_DR : judr_pkg::TAP_IDLE;
            end
            judr_pkg::TAP_SEL_DR: begin
                state_d = tms_pin ? judr_pkg::TAP_SEL_IR : judr_pkg::TAP_CAP_DR;
            end
            judr_pkg::TAP_CAP_DR: begin
                state_d = tms_pin ? judr_pkg::TAP_EX1_DR : judr_pkg::TAP_SHF_DR;
            end
            judr_pkg::TAP_SHF_DR: begin
                state_d = tms_pin ? judr_pkg::TAP_EX1_DR : judr_pkg::TAP_SHF_DR;
            end
            judr_pkg::TAP_EX1_DR: begin
                state_d = tms_pin ? judr_pkg::TAP_UPD_DR : judr_pkg::TAP_PAU_DR;
            end
            judr_pkg::TAP_PAU_DR: begin
                state_d = tms_pin ? judr_pkg::TAP_EX2_DR : judr_pkg::TAP_PAU_DR;
            end
            judr_pkg::TAP_EX2_DR: begin
                state_d = tms_pin ? judr_pkg::TAP_UPD_DR : judr_pkg::TAP_SHF_DR;
            end
            judr_pkg::TAP_UPD_DR: begin
                state_d = tms_pin ? judr_pkg::TAP_SEL_DR : judr_pkg::TAP_IDLE;
            end
            judr_pkg::TAP_SEL_IR: begin
                state_d = tms_pin ? judr_pkg::TAP_RESET : judr_pkg::TAP_CAP_IR;
            end
            judr_pkg::TAP_CAP_IR: begin
                state_d = tms_pin ? judr_pkg::TAP_EX1_IR : judr_pkg::TAP_SHF_IR;
            end
            judr_pkg::TAP_SHF_IR: begin
                state_d = tms_pin ? judr_pkg::TAP_EX1_IR : judr_pkg::TAP_SHF_IR;
            end
            judr_pkg::TAP_EX1_IR: begin
                state_d = tms_pin ? judr_pkg::TAP_UPD_IR : judr_pkg::TAP_PAU_IR;
            end
            judr_pkg::TAP_PAU_IR: begin
                state_d = tms_pin ? judr_pkg::TAP_EX2_IR : judr_pkg::TAP_PAU_IR;
            end
            judr_pkg::TAP_EX2_IR: begin
                state_d = tms_pin ? judr_pkg::TAP_UPD_IR : judr_pkg::TAP_SHF_IR;
            end
            judr_pkg::TAP_UPD_IR: begin
                state_d = tms_pin ? judr_pkg::TAP_SEL_DR : judr_pkg::TAP_IDLE;
            end
            default: begin
                state_d = judr_pkg::TAP_RESET;
            end
        endcase
    end

    always_ff @(posedge tck or negedge nrst) begin
        if (!nrst) begin
            state_q <= judr_pkg::TAP_RESET;
        end else if (tms_pin && tms_run_full) begin
            state_q <= judr_pkg::TAP_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // virtual instruction register
    // ------------------------------------------------------------------
    logic [judr_pkg::VIR_W-1:0] vir_shift_q;
    logic [judr_pkg::VIR_W-1:0] vir_par_q;

    // capture loads the user end's status word, which the host reads back
    // lsb first while the new instruction shifts in behind it
    always_ff @(posedge tck or negedge nrst) begin
        if (!nrst) begin
            vir_shift_q <= judr_pkg::VIR_RESET;
        end else if (state_q == judr_pkg::TAP_CAP_IR) begin
            vir_shift_q <= link.virtual_instr_capture_in;
        end else if (state_q == judr_pkg::TAP_SHF_IR) begin
            vir_shift_q <= {tdi_pin, vir_shift_q[judr_pkg::VIR_W-1:1]}; // RQ6
        end
    end

    // parallel copy changes only on update or in test-logic-reset, so decode stays steady mid-scan
    always_ff @(posedge tck or negedge nrst) begin
        if (!nrst) begin
            vir_par_q <= judr_pkg::VIR_RESET;
        end else if (state_q == judr_pkg::TAP_RESET) begin
            vir_par_q <= judr_pkg::VIR_RESET;
        end else if (state_q == judr_pkg::TAP_UPD_IR) begin
            vir_par_q <= vir_shift_q; // RQ6
        end
    end

    assign link.virtual_instr_parallel_out = vir_par_q; // RQ3

    // ------------------------------------------------------------------
    // state flags
    // ------------------------------------------------------------------
    // each flag compares the whole one-hot state register against one state code
    // they are decoded from the registered state, so each one changes just
    // after a rising tck edge and stands steady for the user logic's next
    // rising edge, which is where the user end samples them
    assign link.shift_data_state_flag = (state_q == judr_pkg::TAP_SHF_DR); // RQ8
    assign link.exit1_data_state_flag = (state_q == judr_pkg::TAP_EX1_DR); // RQ9
    assign link.capture_data_state_flag = (state_q == judr_pkg::TAP_CAP_DR); // RQ13
    assign link.pause_data_state_flag = (state_q == judr_pkg::TAP_PAU_DR); // RQ13
    assign link.exit2_data_state_flag = (state_q == judr_pkg::TAP_EX2_DR); // RQ13
    assign link.update_data_state_flag = (state_q == judr_pkg::TAP_UPD_DR); // RQ13
    assign link.capture_instr_state_flag = (state_q == judr_pkg::TAP_CAP_IR); // RQ13
    assign link.update_instr_state_flag = (state_q == judr_pkg::TAP_UPD_IR); // RQ13

    // ------------------------------------------------------------------
    // tdo pin
    // ------------------------------------------------------------------
    // launched on the falling edge so the host samples a settled bit
    always_ff @(negedge tck or negedge nrst) begin
        if (!nrst) begin
            tdo_pin_oe <= 1'b0;
        end else begin
            tdo_pin_oe <= (state_q == judr_pkg::TAP_SHF_DR) ||
                          (state_q == judr_pkg::TAP_SHF_IR);
        end
    end

    // the data bit keeps its last value outside the shift states
    always_ff @(negedge tck or negedge nrst) begin
        if (!nrst) begin
            tdo_pin_o <= 1'b0;
        end else if (state_q == judr_pkg::TAP_SHF_DR) begin
            tdo_pin_o <= link.tdo; // RQ14
        end else if (state_q == judr_pkg::TAP_SHF_IR) begin
            tdo_pin_o <= vir_shift_q[0];
        end
    end

endmodule : judr_scan_instance

// file: judr_pkg.sv
// shared constants and types for the scan instance and its user logic
package judr_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int VIR_W = 2;
    localparam int UDR_W = 4;

    // ------------------------------------------------------------------
    // instruction codes and reset values
    // ------------------------------------------------------------------
    // shifted lsb first, so a scan of 0 then 1 leaves bit 1 set
    localparam logic [VIR_W-1:0] VIR_SEL_UDR = 2'h2;
    localparam logic [VIR_W-1:0] VIR_RESET = 2'h0;
    localparam logic [VIR_W-1:0] VIR_CAPTURE = 2'h1;
    localparam logic [UDR_W-1:0] UDR_RESET = 4'h0;
    localparam logic [UDR_W-1:0] CNT_RESET = 4'h0;
    localparam logic [UDR_W-1:0] CNT_STEP = 4'h1;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_SYS_PERIOD_NS = 10;
    // tms high cycles that bring the tap into test-logic-reset
    localparam int TAP_RESET_TMS_CYCLES = 5;

    // ------------------------------------------------------------------
    // tap controller states
    // ------------------------------------------------------------------
    typedef enum logic [15:0] {
        TAP_RESET = 16'h0001,
        TAP_IDLE = 16'h0002,
        TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008,
        TAP_SHF_DR = 16'h0010,
        TAP_EX1_DR = 16'h0020,
        TAP_PAU_DR = 16'h0040,
        TAP_EX2_DR = 16'h0080,
        TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400,
        TAP_SHF_IR = 16'h0800,
        TAP_EX1_IR = 16'h1000,
        TAP_PAU_IR = 16'h2000,
        TAP_EX2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } judr_tap_state_t;

endpackage : judr_pkg

// file: judr_link_if.sv
// link between the scan instance and the user logic behind it
`timescale 1ns/1ps
interface judr_link_if;
    logic scan_clk;
    logic tms;
    logic tdi;
    logic tdo;
    logic [judr_pkg::VIR_W-1:0] virtual_instr_parallel_out;
    logic [judr_pkg::VIR_W-1:0] virtual_instr_capture_in;
    logic capture_data_state_flag;
    logic shift_data_state_flag;
    logic exit1_data_state_flag;
    logic pause_data_state_flag;
    logic exit2_data_state_flag;
    logic update_data_state_flag;
    logic capture_instr_state_flag;
    logic update_instr_state_flag;

    modport dev_mp (
        output scan_clk,
        output tms,
        output tdi,
        input tdo,
        output virtual_instr_parallel_out,
        input virtual_instr_capture_in,
        output capture_data_state_flag,
        output shift_data_state_flag,
        output exit1_data_state_flag,
        output pause_data_state_flag,
        output exit2_data_state_flag,
        output update_data_state_flag,
        output capture_instr_state_flag,
        output update_instr_state_flag
    );

    modport usr_mp (
        input scan_clk,
        input tms,
        input tdi,
        output tdo,
        input virtual_instr_parallel_out,
        output virtual_instr_capture_in,
        input capture_data_state_flag,
        input shift_data_state_flag,
        input exit1_data_state_flag,
        input pause_data_state_flag,
        input exit2_data_state_flag,
        input update_data_state_flag,
        input capture_instr_state_flag,
        input update_instr_state_flag
    );
endinterface : judr_link_if

// file: judr_sync2.sv
// two-stage level synchroniser into the destination clock
`timescale 1ns/1ps
module judr_sync2 (
    input wire logic clk,
    input wire logic nrst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    // meta_q feeds only the second stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : judr_sync2

// file: judr_user_logic.sv
// user logic: decode, data register, bypass, return mux and counter
`timescale 1ns/1ps
module judr_user_logic #(
    parameter int CNT_W = judr_pkg::UDR_W
) (
    input wire logic clk_sys,
    input wire logic nrst,
    judr_link_if.usr_mp link,
    output logic [CNT_W-1:0] loadable_up_counter
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic udr_sel;
    assign udr_sel = (link.virtual_instr_parallel_out == judr_pkg::VIR_SEL_UDR); // RQ4 RQ5
    assign link.virtual_instr_capture_in = judr_pkg::VIR_CAPTURE;

    // ------------------------------------------------------------------
    // scan clock domain
    // ------------------------------------------------------------------
    logic [judr_pkg::UDR_W-1:0] udr_q;
    logic bypass_q;
    logic [judr_pkg::UDR_W-1:0] hold_q;
    logic load_tgl_q;

    always_ff @(posedge link.scan_clk or negedge nrst) begin
        if (!nrst) begin
            udr_q <= judr_pkg::UDR_RESET;
        end else if (udr_sel && link.shift_data_state_flag) begin
            udr_q <= {link.tdi, udr_q[judr_pkg::UDR_W-1:1]}; // RQ7
        end
    end

    always_ff @(posedge link.scan_clk or negedge nrst) begin
        if (!nrst) begin
            bypass_q <= 1'b0;
        end else begin
            bypass_q <= link.tdi; // RQ15
        end
    end

    assign link.tdo = udr_sel ? udr_q[0] : bypass_q; // RQ11 RQ12

    // the word is parked here so it stays put while the counter side
    // takes it, even if a new shift starts before the crossing is done
    always_ff @(posedge link.scan_clk or negedge nrst) begin
        if (!nrst) begin
            hold_q <= judr_pkg::UDR_RESET;
            load_tgl_q <= 1'b0;
        end else if (udr_sel && link.exit1_data_state_flag) begin
            hold_q <= udr_q; // RQ10
            load_tgl_q <= ~load_tgl_q;
        end
    end

    // ------------------------------------------------------------------
    // system clock domain
    // ------------------------------------------------------------------
    logic tgl_sync;
    logic tgl_seen_q;
    logic load_now;

    judr_sync2 u_tgl_sync (
        .clk(clk_sys),
        .nrst(nrst),
        .async_in(load_tgl_q),
        .sync_out(tgl_sync)
    );

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tgl_seen_q <= 1'b0;
        end else begin
            tgl_seen_q <= tgl_sync;
        end
    end

    assign load_now = tgl_sync ^ tgl_seen_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            loadable_up_counter <= CNT_W'(judr_pkg::CNT_RESET);
        end else if (load_now) begin
            loadable_up_counter <= CNT_W'(hold_q); // RQ10
        end else begin
            loadable_up_counter <= loadable_up_counter + CNT_W'(judr_pkg::CNT_STEP); // RQ10
        end
    end

endmodule : judr_user_logic

// file: judr_link_asserts.sv
// concurrent checks on the link between the scan instance and its user logic
`timescale 1ns/1ps
module judr_link_asserts #(
    parameter int CNT_W = judr_pkg::UDR_W
) (
    input logic clk_sys,
    input logic nrst,
    input logic [CNT_W-1:0] loadable_up_counter,
    input logic scan_clk,
    input logic tms,
    input logic tdi,
    input logic tdo,
    input logic [judr_pkg::VIR_W-1:0] virtual_instr_parallel_out,
    input logic capture_data_state_flag,
    input logic shift_data_state_flag,
    input logic exit1_data_state_flag,
    input logic exit2_data_state_flag,
    input logic update_data_state_flag,
    input logic update_instr_state_flag,
    input logic pause_data_state_flag,
    input logic capture_instr_state_flag
);
    logic sel;
    logic [3:0] since_q;

    assign sel = virtual_instr_parallel_out == judr_pkg::VIR_SEL_UDR;

    // cycles since a selected exit1 was seen; zero at reset so release looks like a load
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            since_q <= 4'h0;
        end else if (sel && exit1_data_state_flag) begin
            since_q <= 4'h0;
        end else if (since_q != 4'hF) begin
            since_q <= since_q + 4'h1;
        end
    end

    sequence s_sel_shift4;
        (sel && shift_data_state_flag) [*4];
    endsequence

    // ------------------------------------------------------------------
    // scan clock domain
    // ------------------------------------------------------------------
    chk_bypass_delay: assert property (@(posedge scan_clk) disable iff (!nrst)
        !sel && $past(nrst) |-> tdo == $past(tdi)) else $error("bypass delay wrong");
    chk_udr_return: assert property (@(posedge scan_clk) disable iff (!nrst)
        s_sel_shift4 |=> tdo == $past(tdi, 4)) else $error("data register return wrong");
    chk_shift_hold: assert property (@(posedge scan_clk) disable iff (!nrst)
        shift_data_state_flag && !tms |=> shift_data_state_flag) else $error("shift dropped");
    chk_shift_leave: assert property (@(posedge scan_clk) disable iff (!nrst)
        shift_data_state_flag && tms |=> exit1_data_state_flag && !shift_data_state_flag)
        else $error("exit1 not after shift");
    chk_exit_entry: assert property (@(posedge scan_clk) disable iff (!nrst)
        $rose(exit1_data_state_flag) |-> $past(shift_data_state_flag)
        || $past(capture_data_state_flag)) else $error("exit1 from wrong state");
    chk_cap_shift: assert property (@(posedge scan_clk) disable iff (!nrst)
        capture_data_state_flag && !tms |=> shift_data_state_flag) else $error("no shift");
    chk_upd_entry: assert property (@(posedge scan_clk) disable iff (!nrst)
        update_data_state_flag |-> $past(exit1_data_state_flag) || $past(exit2_data_state_flag))
        else $error("update from wrong state");
    chk_vir_update: assert property (@(posedge scan_clk) disable iff (!nrst)
        !$stable(virtual_instr_parallel_out) |-> $past(update_instr_state_flag)
        || virtual_instr_parallel_out == judr_pkg::VIR_RESET) else $error("instr changed");
    chk_flags_onehot: assert property (@(posedge scan_clk) disable iff (!nrst)
        $onehot0({capture_data_state_flag, shift_data_state_flag, exit1_data_state_flag,
        exit2_data_state_flag, update_data_state_flag, update_instr_state_flag,
        pause_data_state_flag, capture_instr_state_flag}))
        else $error("state flags overlap");

    // ------------------------------------------------------------------
    // system clock domain
    // ------------------------------------------------------------------
    chk_cnt_load: assert property (@(posedge clk_sys) disable iff (!nrst)
        loadable_up_counter != $past(loadable_up_counter) + judr_pkg::CNT_STEP
        |-> since_q <= 4'h8) else $error("counter jumped without a load");
endmodule : judr_link_asserts

// file: jtag_user_data_register_tb_top.sv
// self-checking bench: both ends joined by the link, scans driven at the jtag pins
`timescale 1ns/1ps
module jtag_user_data_register_tb_top;
`define CHK(a, b) begin \
    checked++; \
    if ((a) !== (b)) begin \
        miscompares++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
end
    logic clk_sys = 1'b0;
    logic tck = 1'b0;
    logic nrst = 1'b0;
    logic tms_pin = 1'b1;
    logic tdi_pin = 1'b0;
    logic tdo_pin_o;
    logic tdo_pin_oe;
    logic [3:0] cnt;
    logic [3:0] prev_cnt = 4'h0;
    logic prev_live = 1'b0;
    logic load_seen = 1'b0;
    int load_win = 0;
    int breaks = 0;
    logic [3:0] udr_m = judr_pkg::UDR_RESET;
    logic [3:0] ldq[$];
    logic [7:0] o;
    logic [7:0] b;
    int miscompares = 0;
    int checked = 0;
    int seed = 32'hAD7F;

    always #5 clk_sys = ~clk_sys;
    always #7.5 tck = ~tck;

    judr_link_if lk();
    judr_scan_instance judr_scan_instance_i (.tck(tck), .nrst(nrst), .tms_pin(tms_pin),
        .tdi_pin(tdi_pin), .tdo_pin_o(tdo_pin_o), .tdo_pin_oe(tdo_pin_oe), .link(lk));
    judr_user_logic #(.CNT_W(judr_pkg::UDR_W)) judr_user_logic_i (.clk_sys(clk_sys),
        .nrst(nrst), .link(lk), .loadable_up_counter(cnt));
    judr_link_asserts #(.CNT_W(judr_pkg::UDR_W)) judr_link_asserts_i (.clk_sys(clk_sys),
        .nrst(nrst), .loadable_up_counter(cnt), .scan_clk(lk.scan_clk), .tms(lk.tms),
        .tdi(lk.tdi), .tdo(lk.tdo), .virtual_instr_parallel_out(lk.virtual_instr_parallel_out),
        .capture_data_state_flag(lk.capture_data_state_flag),
        .shift_data_state_flag(lk.shift_data_state_flag),
        .exit1_data_state_flag(lk.exit1_data_state_flag),
        .exit2_data_state_flag(lk.exit2_data_state_flag),
        .update_data_state_flag(lk.update_data_state_flag),
        .update_instr_state_flag(lk.update_instr_state_flag),
        .pause_data_state_flag(lk.pause_data_state_flag),
        .capture_instr_state_flag(lk.capture_instr_state_flag));

    // ------------------------------------------------------------------
    // model: the counter steps by one on every edge, except that the word
    // queued by a selected data scan must show up inside a short window;
    // an increment that lands on that word cannot be told from the load
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (nrst && prev_live) begin
            if (load_win > 0 && ldq.size() > 0 && cnt === ldq[0]) begin
                load_seen = 1'b1;
                load_win = (cnt === prev_cnt + 4'h1) ? load_win - 1 : 0;
            end else begin
                breaks += (cnt !== prev_cnt + 4'h1) ? 1 : 0;
                `CHK(cnt, prev_cnt + 4'h1)
                load_win = (load_win > 0) ? load_win - 1 : 0;
            end
        end
        prev_cnt = cnt;
        prev_live = nrst;
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic jstep(input logic m, input logic d, output logic r);
        tms_pin <= m;
        tdi_pin <= d;
        @(posedge lk.scan_clk);
        r = tdo_pin_o;
        `CHK(lk.tms, tms_pin)
        `CHK(lk.scan_clk, tck)
    endtask : jstep

    task automatic idle(input int n);
        logic x;
        repeat (n) jstep(1'b0, 1'($random(seed)), x);
    endtask : idle

    task automatic tap_reset();
        logic x;
        repeat (5) jstep(1'b1, 1'b0, x);
        idle(2);
        `CHK(lk.virtual_instr_parallel_out, judr_pkg::VIR_RESET)
    endtask : tap_reset

    task automatic scan(input logic ir, input int n, input logic [7:0] d);
        logic x;
        logic p;
        p = 1'($random(seed));
        jstep(1'b1, p, x);
        if (ir) begin
            jstep(1'b1, p, x);
        end
        jstep(1'b0, p, x);
        jstep(1'b0, p, x);
        `CHK(ir ? lk.capture_instr_state_flag : lk.capture_data_state_flag, 1'b1)
        for (int i = 0; i < n; i++) begin
            b[i] = p;
            jstep(i == n - 1, d[i], o[i]);
            p = d[i];
            `CHK(tdo_pin_oe, 1'b1)
            `CHK(lk.shift_data_state_flag, !ir)
        end
        jstep(1'b1, p, x);
        `CHK(lk.exit1_data_state_flag, !ir)
        jstep(1'b0, p, x);
        `CHK(ir ? lk.update_instr_state_flag : lk.update_data_state_flag, 1'b1)
    endtask : scan

    task automatic ir_set(input logic [1:0] code);
        scan(1'b1, 2, {6'h00, code});
        `CHK(o[1:0], judr_pkg::VIR_CAPTURE)
        idle(1);
        `CHK(lk.virtual_instr_parallel_out, code)
    endtask : ir_set

    task automatic dr_load(input logic [3:0] v);
        scan(1'b0, 4, {4'h0, v});
        `CHK(o[3:0], udr_m)
        udr_m = v;
        ldq.delete();
        ldq.push_back(v);
        load_seen = 1'b0;
        load_win = 5;
        idle(8);
        `CHK(load_seen, 1'b1)
    endtask : dr_load

    task automatic report_and_stop();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #50000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge tck);
        tap_reset();
        ir_set(judr_pkg::VIR_SEL_UDR);
        repeat (4) dr_load(4'($random(seed)));
        $display("test selected loads done");
        ir_set(2'h0);
        breaks = 0;
        scan(1'b0, 8, 8'($random(seed)));
        `CHK(o, b)
        idle(8);
        `CHK(breaks, 0)
        ir_set(judr_pkg::VIR_SEL_UDR);
        dr_load(4'hA);
        $display("test bypass done");
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        udr_m = judr_pkg::UDR_RESET;
        @(posedge tck);
        tap_reset();
        ir_set(judr_pkg::VIR_SEL_UDR);
        dr_load(4'h5);
        tap_reset();
        $display("test resets done");
        report_and_stop();
    end
endmodule : jtag_user_data_register_tb_top
